// file: hdl/alm_regs.vh
`ifndef ALM_REGS_VH
`define ALM_REGS_VH
// Register byte addresses
`define ALM_ADDR_FLAGS2      11'h512
`define ALM_ADDR_FLAGS3      11'h513
`define ALM_ADDR_S0_LOW      11'h514
`define ALM_ADDR_S0_MIXED    11'h515
`define ALM_ADDR_S0_HIGH     11'h516
`define ALM_ADDR_S0_CFG      11'h517
`define ALM_ADDR_S1_LOW      11'h518
// Flag bit positions; input 0 flag in its own register, the rest in the self-test and temperature register
`define ALM_BIT_REF_DIV1     6
`define ALM_BIT_REF_DIV2     5
`define ALM_BIT_REF_DIV4     4
`define ALM_BIT_REF_DIV8     3
`define ALM_BIT_TEMP_ERR     1
`define ALM_BIT_IN0_LOW      0
// Reset values
`define ALM_RST_S0_LOW       8'h00
`define ALM_RST_S0_LOLSB2    2'h0
`define ALM_RST_S0_HINIB     4'hF
`define ALM_RST_S0_HIGH      6'h3F
`define ALM_RST_S0_DIV       2'h0
`define ALM_RST_S0_CHOICE    4'h3
`define ALM_RST_S1_LOW       8'h00
// Input choice codes
`define ALM_CH_EXT0          4'h0
`define ALM_CH_EXT1          4'h1
`define ALM_CH_EXT2          4'h2
`define ALM_CH_IO_Q          4'h8
`define ALM_CH_V18_H         4'h9
`define ALM_CH_CAP_H         4'hA
`endif

// file: hdl/alm_limit_regs.v
// How it works
// - Input 0 under-threshold flag sits at bit 0, cleared by reading its register.
// - Bit 6 sets when divide-by-one self-test reference exceeds its limit.
// - Bits 5, 4, 3 set for divide-by-2, 4, 8 self-test over-limit.
// - Self-test and temperature flags are read-only and clear on read.
// - Set 0 low bound low byte is a read-write byte.
// - Bits 1:0 of mixed register give low bound top two bits.
// - Bits 7:4 of mixed register give high bound low nibble; 3:2 unused.
// - Upper six high-bound bits in third register; high bound resets all ones.
// - Choice field decodes external inputs 0-2, supplies at 8, 9, A; rest reserved.
`include "alm_regs.vh"
module alm_limit_regs #(
    parameter AW = 11
) (
    input  wire          clk_i,
    input  wire          rstn_i,
    input  wire [AW-1:0] addr_i,
    input  wire          wr_i,
    input  wire          rd_i,
    input  wire [7:0]    wdata_i,
    input  wire          in0_low_evt_i,
    input  wire          ref_div1_evt_i,
    input  wire          ref_div2_evt_i,
    input  wire          ref_div4_evt_i,
    input  wire          ref_div8_evt_i,
    input  wire          temp_mismatch_evt_i,
    output reg  [7:0]    rdata_o,
    output wire [9:0]    set0_low_bound_o,
    output wire [9:0]    set0_high_bound_o,
    output wire [1:0]    set0_input_divider_o,
    output wire [2:0]    set0_divide_ratio_o,
    output wire [3:0]    set0_input_choice_o,
    output wire          set0_choice_valid_o,
    output wire [2:0]    set0_ext_input_sel_o,
    output wire [2:0]    set0_supply_sel_o,
    output wire [7:0]    set1_lower_bound_lsbs_o
);

    reg [7:0] set0_lower_bound_lsbs_r;
    reg [1:0] set0_lower_bound_msbs_r;
    reg [3:0] set0_upper_bound_lsbs_r;
    reg [5:0] set0_upper_bound_msbs_r;
    reg [1:0] set0_input_divider_r;
    reg [3:0] set0_input_choice_r;
    reg [7:0] set1_lower_bound_lsbs_r;
    reg       input0_under_threshold_flag_r;
    reg       selftest_full_over_flag_r;
    reg       selftest_half_over_flag_r;
    reg       selftest_quarter_over_flag_r;
    reg       selftest_eighth_over_flag_r;
    reg       thermal_mismatch_flag_r;
    reg [7:0] rdata_nxt;
    // Decoded copies of the divider and choice fields, kept in flip-flops
    reg [2:0] set0_divide_ratio_r;
    reg [2:0] set0_ext_input_sel_r;
    reg [2:0] set0_supply_sel_r;
    reg       set0_choice_valid_r;

    wire rd_flags2 = rd_i && (addr_i == `ALM_ADDR_FLAGS2);
    wire rd_flags3 = rd_i && (addr_i == `ALM_ADDR_FLAGS3);

    // Sticky flag update: event wins over clear-on-read
    function flag_next;
        input cur;
        input evt;
        input clr;
        begin
            flag_next = evt | (cur & ~clr);
        end
    endfunction

    // Divider code to division ratio: code plus one
    function [2:0] ratio_of;
        input [1:0] code;
        begin
            ratio_of = {1'b0, code} + 3'h1;
        end
    endfunction

    // One-hot of an external input code; zero for any other code
    function [2:0] ext_onehot;
        input [3:0] code;
        begin
            ext_onehot = 3'h0;
            case (code)
                `ALM_CH_EXT0: ext_onehot = 3'h1;
                `ALM_CH_EXT1: ext_onehot = 3'h2;
                `ALM_CH_EXT2: ext_onehot = 3'h4;
                default:      ext_onehot = 3'h0;
            endcase
        end
    endfunction

    // One-hot of an internal supply code; zero for any other code
    function [2:0] supply_onehot;
        input [3:0] code;
        begin
            supply_onehot = 3'h0;
            case (code)
                `ALM_CH_IO_Q:  supply_onehot = 3'h1;
                `ALM_CH_V18_H: supply_onehot = 3'h2;
                `ALM_CH_CAP_H: supply_onehot = 3'h4;
                default:       supply_onehot = 3'h0;
            endcase
        end
    endfunction

    // A choice code is usable when it names an input or a supply
    function choice_known;
        input [3:0] code;
        begin
            choice_known = |{ext_onehot(code), supply_onehot(code)};
        end
    endfunction

    // Clear-on-read event flags
    // An event in the same cycle as the clearing read is kept, so a late
    // comparison result is never lost between two polls of software.
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            input0_under_threshold_flag_r <= 1'b0;
            selftest_full_over_flag_r     <= 1'b0;
            selftest_half_over_flag_r     <= 1'b0;
            selftest_quarter_over_flag_r  <= 1'b0;
            selftest_eighth_over_flag_r   <= 1'b0;
            thermal_mismatch_flag_r       <= 1'b0;
        end else begin
            input0_under_threshold_flag_r <= flag_next(input0_under_threshold_flag_r,
                                                       in0_low_evt_i, rd_flags2);
            selftest_full_over_flag_r    <= flag_next(selftest_full_over_flag_r,
                                                      ref_div1_evt_i, rd_flags3);
            selftest_half_over_flag_r    <= flag_next(selftest_half_over_flag_r,
                                                      ref_div2_evt_i, rd_flags3);
            selftest_quarter_over_flag_r <= flag_next(selftest_quarter_over_flag_r,
                                                      ref_div4_evt_i, rd_flags3);
            selftest_eighth_over_flag_r  <= flag_next(selftest_eighth_over_flag_r,
                                                      ref_div8_evt_i, rd_flags3);
            thermal_mismatch_flag_r      <= flag_next(thermal_mismatch_flag_r,
                                                      temp_mismatch_evt_i, rd_flags3);
        end
    end

    // Threshold and input configuration registers
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            set0_lower_bound_lsbs_r <= `ALM_RST_S0_LOW;
            set0_lower_bound_msbs_r <= `ALM_RST_S0_LOLSB2;
            set0_upper_bound_lsbs_r <= `ALM_RST_S0_HINIB;
            set0_upper_bound_msbs_r <= `ALM_RST_S0_HIGH;
            set0_input_divider_r    <= `ALM_RST_S0_DIV;
            set0_input_choice_r     <= `ALM_RST_S0_CHOICE;
            set1_lower_bound_lsbs_r <= `ALM_RST_S1_LOW;
        end else if (wr_i) begin
            case (addr_i)
                `ALM_ADDR_S0_LOW: begin
                    set0_lower_bound_lsbs_r <= wdata_i;
                end
                `ALM_ADDR_S0_MIXED: begin
                    set0_lower_bound_msbs_r <= wdata_i[1:0];
                    set0_upper_bound_lsbs_r <= wdata_i[7:4];
                end
                `ALM_ADDR_S0_HIGH: begin
                    set0_upper_bound_msbs_r <= wdata_i[5:0];
                end
                `ALM_ADDR_S0_CFG: begin
                    set0_input_divider_r <= wdata_i[5:4];
                    set0_input_choice_r  <= wdata_i[3:0];
                end
                `ALM_ADDR_S1_LOW: begin
                    set1_lower_bound_lsbs_r <= wdata_i;
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; unused and reserved bits read zero, unmapped reads zero
    always @* begin
        rdata_nxt = 8'h00;
        case (addr_i)
            `ALM_ADDR_FLAGS2: begin
                rdata_nxt[`ALM_BIT_IN0_LOW] = input0_under_threshold_flag_r;
            end
            `ALM_ADDR_FLAGS3: begin
                rdata_nxt[`ALM_BIT_REF_DIV1] = selftest_full_over_flag_r;
                rdata_nxt[`ALM_BIT_REF_DIV2] = selftest_half_over_flag_r;
                rdata_nxt[`ALM_BIT_REF_DIV4] = selftest_quarter_over_flag_r;
                rdata_nxt[`ALM_BIT_REF_DIV8] = selftest_eighth_over_flag_r;
                rdata_nxt[`ALM_BIT_TEMP_ERR] = thermal_mismatch_flag_r;
            end
            `ALM_ADDR_S0_LOW: begin
                rdata_nxt = set0_lower_bound_lsbs_r;
            end
            `ALM_ADDR_S0_MIXED: begin
                rdata_nxt = {set0_upper_bound_lsbs_r, 2'h0, set0_lower_bound_msbs_r};
            end
            `ALM_ADDR_S0_HIGH: begin
                rdata_nxt = {2'h0, set0_upper_bound_msbs_r};
            end
            `ALM_ADDR_S0_CFG: begin
                rdata_nxt = {2'h0, set0_input_divider_r, set0_input_choice_r};
            end
            `ALM_ADDR_S1_LOW: begin
                rdata_nxt = set1_lower_bound_lsbs_r;
            end
            default: begin
                rdata_nxt = 8'h00;
            end
        endcase
    end

    // Read data registered on a read strobe
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            rdata_o <= rdata_nxt;
        end
    end

    // Assembled 10-bit bounds
    // Each byte takes effect at once; a bound is mixed between two byte writes
    assign set0_low_bound_o  = {set0_lower_bound_msbs_r, set0_lower_bound_lsbs_r};
    assign set0_high_bound_o = {set0_upper_bound_msbs_r, set0_upper_bound_lsbs_r};
    assign set1_lower_bound_lsbs_o = set1_lower_bound_lsbs_r;

    // Decoded divider and choice, loaded together with the raw fields
    // Decoding the write data keeps the decoded copy in step with the field,
    // so no cycle shows a new field beside an old decode.
    always @(posedge clk_i) begin
        if (!rstn_i) begin
            set0_divide_ratio_r  <= ratio_of(`ALM_RST_S0_DIV);
            set0_ext_input_sel_r <= ext_onehot(`ALM_RST_S0_CHOICE);
            set0_supply_sel_r    <= supply_onehot(`ALM_RST_S0_CHOICE);
            set0_choice_valid_r  <= choice_known(`ALM_RST_S0_CHOICE);
        end else if (wr_i && (addr_i == `ALM_ADDR_S0_CFG)) begin
            set0_divide_ratio_r  <= ratio_of(wdata_i[5:4]);
            set0_ext_input_sel_r <= ext_onehot(wdata_i[3:0]);
            set0_supply_sel_r    <= supply_onehot(wdata_i[3:0]);
            set0_choice_valid_r  <= choice_known(wdata_i[3:0]);
        end
    end

    // Raw divider and choice fields
    assign set0_input_divider_o = set0_input_divider_r;
    assign set0_input_choice_o  = set0_input_choice_r;

    // Decoded divider and choice; reserved codes select nothing
    assign set0_divide_ratio_o  = set0_divide_ratio_r;
    assign set0_ext_input_sel_o = set0_ext_input_sel_r;
    assign set0_supply_sel_o    = set0_supply_sel_r;
    assign set0_choice_valid_o  = set0_choice_valid_r;

endmodule

// file: verif/alm_limit_regs_asserts.sv
module alm_limit_regs_asserts (
    input logic        clk_i,
    input logic        rstn_i,
    input logic [10:0] addr_i,
    input logic        wr_i,
    input logic        rd_i,
    input logic [7:0]  wdata_i,
    input logic        in0_low_evt_i,
    input logic        ref_div1_evt_i,
    input logic        ref_div2_evt_i,
    input logic        ref_div4_evt_i,
    input logic        ref_div8_evt_i,
    input logic        temp_mismatch_evt_i,
    input logic [7:0]  rdata_o,
    input logic [9:0]  set0_low_bound_o,
    input logic [9:0]  set0_high_bound_o,
    input logic [1:0]  set0_input_divider_o,
    input logic [2:0]  set0_divide_ratio_o,
    input logic [3:0]  set0_input_choice_o,
    input logic        set0_choice_valid_o,
    input logic [7:0]  set1_lower_bound_lsbs_o
);
    // Any self-test or temperature flag event pending (input 0 event not included)
    wire ev = ref_div1_evt_i | ref_div2_evt_i | ref_div4_evt_i | ref_div8_evt_i
              | temp_mismatch_evt_i;
    wire rd3 = rd_i && addr_i == 11'h513 && !ev;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_low_byte_wr: assert property (wr_i && addr_i == 11'h514 |=>
        set0_low_bound_o[7:0] == $past(wdata_i)) else $error("low byte write lost");
    a_mixed_wr: assert property (wr_i && addr_i == 11'h515 |=>
        {set0_low_bound_o[9:8], set0_high_bound_o[3:0]} == {$past(wdata_i[1:0]),
        $past(wdata_i[7:4])}) else $error("mixed byte write lost");
    a_high_upper_wr: assert property (wr_i && addr_i == 11'h516 |=>
        set0_high_bound_o[9:4] == $past(wdata_i[5:0])) else $error("high write lost");
    a_cfg_wr: assert property (wr_i && addr_i == 11'h517 |=>
        {set0_input_divider_o, set0_input_choice_o} == $past(wdata_i[5:0]))
        else $error("config write lost");
    a_ratio_map: assert property (
        set0_divide_ratio_o == {1'b0, set0_input_divider_o} + 3'h1)
        else $error("divide ratio wrong");
    a_choice_ok: assert property (set0_choice_valid_o ==
        (set0_input_choice_o <= 4'h2 ||
         (set0_input_choice_o >= 4'h8 && set0_input_choice_o <= 4'hA)))
        else $error("choice validity wrong");
    a_flag_clear: assert property (rd3 ##1 rd3 |=> rdata_o == 8'h00)
        else $error("flags not cleared on read");
    a_selftest_set: assert property (ref_div1_evt_i ##1
        (rd_i && addr_i == 11'h513) |=> rdata_o[6])
        else $error("self-test flag missing");
    a_in0_set: assert property (in0_low_evt_i ##1
        (rd_i && addr_i == 11'h512) |=> rdata_o[0])
        else $error("input 0 flag missing");
endmodule

// file: verif/alm_limit_regs_test.sv
module alm_limit_regs_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [10:0] addr_i = 11'h000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [7:0]  wdata_i = 8'h00;
    logic [6:0]  ev = 7'h00;
    logic [7:0]  rdata_o, s1_o, v1, v2;
    logic [9:0]  lo_o, hi_o;
    logic [3:0]  ch_o;
    logic [2:0]  rat_o, ext_o, sup_o;
    logic [1:0]  dv_o;
    logic        val_o;
    int          fails = 0;
    int          n_compared = 0;
    // Free-running clock
    always #50 clk_i = ~clk_i;
    alm_limit_regs DUT (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wr_i(wr_i),
        .rd_i(rd_i), .wdata_i(wdata_i), .in0_low_evt_i(ev[0]), .ref_div1_evt_i(ev[6]),
        .ref_div2_evt_i(ev[5]), .ref_div4_evt_i(ev[4]), .ref_div8_evt_i(ev[3]),
        .temp_mismatch_evt_i(ev[1]), .rdata_o(rdata_o), .set0_low_bound_o(lo_o),
        .set0_high_bound_o(hi_o), .set0_input_divider_o(dv_o), .set0_divide_ratio_o(rat_o),
        .set0_input_choice_o(ch_o), .set0_choice_valid_o(val_o), .set0_ext_input_sel_o(ext_o),
        .set0_supply_sel_o(sup_o), .set1_lower_bound_lsbs_o(s1_o));
    task chk(input string n, input logic [9:0] s, input logic [9:0] e);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input logic [10:0] a, input logic [7:0] d);
        @(negedge clk_i) {addr_i, wdata_i, wr_i} = {a, d, 1'b1};
        @(negedge clk_i) wr_i = 1'b0;
    endtask
    // Optional event pulse, then two back-to-back reads
    task rd2(input logic [10:0] a, input logic [6:0] e);
        @(negedge clk_i) ev = e;
        @(negedge clk_i) {ev, addr_i, rd_i} = {7'h00, a, 1'b1};
        @(negedge clk_i) v1 = rdata_o;
        @(negedge clk_i) {rd_i, v2} = {1'b0, rdata_o};
    endtask
    task t_reset;
        logic [7:0] rv [5] = '{8'h00, 8'hF0, 8'h3F, 8'h03, 8'h00};
        for (int i = 0; i < 5; i++) begin
            rd2(11'h514 + 11'(i), 7'h00);
            chk("reset read", v1, rv[i]);
        end
        chk("high bound", hi_o, 10'h3FF);
        chk("low bound", lo_o, 10'h000);
    endtask
    task t_rw;
        wr(11'h514, 8'hA5);
        wr(11'h515, 8'hAF);
        wr(11'h516, 8'hD5);
        wr(11'h518, 8'h5A);
        chk("low bound", lo_o, 10'h3A5);
        chk("high bound", hi_o, 10'h15A);
        chk("set1 low", s1_o, 10'h05A);
        rd2(11'h515, 7'h00);
        chk("mixed read", v1, 10'h0A3);
        rd2(11'h516, 7'h00);
        chk("high read", v2, 10'h015);
    endtask
    task t_cfg;
        for (int c = 0; c < 16; c++) begin
            wr(11'h517, {2'b11, 2'(c), 4'(c)});
            rd2(11'h517, 7'h00);
            chk("config read", v1, {4'h0, 2'(c), 4'(c)});
            chk("divider", dv_o, 10'(c % 4));
            chk("choice", ch_o, 10'(c));
            chk("ratio", rat_o, 10'(c % 4 + 1));
            chk("valid", val_o, 10'(c < 3 || (c > 7 && c < 11)));
            chk("ext sel", ext_o, c < 3 ? 10'(1 << c) : 10'h0);
            chk("supply sel", sup_o, (c > 7 && c < 11) ? 10'(1 << (c - 8)) : 10'h0);
        end
    endtask
    task t_flags;
        for (int i = 0; i < 7; i++) if (i != 2) begin
            rd2(i == 0 ? 11'h512 : 11'h513, 7'(1 << i));
            chk("flag set", v1, 10'(1 << i));
            chk("flag clear", v2, 10'h000);
        end
        wr(11'h513, 8'hFF);
        rd2(11'h513, 7'h00);
        chk("flag write", v1, 10'h000);
        rd2(11'h600, 7'h00);
        chk("unmapped", v1, 10'h000);
    endtask
    task report_and_stop;
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk_i);
        rstn_i = 1'b1;
        t_reset();
        t_rw();
        t_cfg();
        t_flags();
        report_and_stop();
    end
endmodule
bind alm_limit_regs alm_limit_regs_asserts u_chk (.*);
